/* File: core/gos_pkg.sv */
package gos_pkg;

   // ****************************************************************
   // widths and counts
   // ****************************************************************
   localparam int GOS_AXES = 3;
   localparam int GOS_ST_REGS = 6;
   localparam int GOS_DW = 8;
   localparam int GOS_SW = 16;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0] GOS_GYRO_X_SELFTEST_CODE = 8'h00;
   localparam logic [7:0] GOS_GYRO_Y_SELFTEST_CODE = 8'h01;
   localparam logic [7:0] GOS_GYRO_Z_SELFTEST_CODE = 8'h02;
   localparam logic [7:0] GOS_ACCEL_X_SELFTEST_CODE = 8'h0D;
   localparam logic [7:0] GOS_ACCEL_Y_SELFTEST_CODE = 8'h0E;
   localparam logic [7:0] GOS_ACCEL_Z_SELFTEST_CODE = 8'h0F;
   localparam logic [7:0] GOS_GYRO_X_BIAS_HIGH = 8'h13;
   localparam logic [7:0] GOS_GYRO_X_BIAS_LOW = 8'h14;
   localparam logic [7:0] GOS_GYRO_Y_BIAS_HIGH = 8'h15;
   localparam logic [7:0] GOS_GYRO_Y_BIAS_LOW = 8'h16;
   localparam logic [7:0] GOS_GYRO_Z_BIAS_HIGH = 8'h17;
   localparam logic [7:0] GOS_GYRO_Z_BIAS_LOW = 8'h18;
   localparam logic [7:0] GOS_GYRO_X_OUT_HIGH = 8'h43;
   localparam logic [7:0] GOS_GYRO_X_OUT_LOW = 8'h44;
   localparam logic [7:0] GOS_GYRO_Y_OUT_HIGH = 8'h45;
   localparam logic [7:0] GOS_GYRO_Y_OUT_LOW = 8'h46;
   localparam logic [7:0] GOS_GYRO_Z_OUT_HIGH = 8'h47;
   localparam logic [7:0] GOS_GYRO_Z_OUT_LOW = 8'h48;

   // index 0..5: gyro x,y,z then accel x,y,z
   localparam logic [GOS_ST_REGS-1:0][7:0] GOS_ST_ADDR = {
      GOS_ACCEL_Z_SELFTEST_CODE, GOS_ACCEL_Y_SELFTEST_CODE, GOS_ACCEL_X_SELFTEST_CODE,
      GOS_GYRO_Z_SELFTEST_CODE, GOS_GYRO_Y_SELFTEST_CODE, GOS_GYRO_X_SELFTEST_CODE};
   localparam logic [GOS_AXES-1:0][7:0] GOS_BIAS_HI_ADDR = {
      GOS_GYRO_Z_BIAS_HIGH, GOS_GYRO_Y_BIAS_HIGH, GOS_GYRO_X_BIAS_HIGH};
   localparam logic [GOS_AXES-1:0][7:0] GOS_BIAS_LO_ADDR = {
      GOS_GYRO_Z_BIAS_LOW, GOS_GYRO_Y_BIAS_LOW, GOS_GYRO_X_BIAS_LOW};
   localparam logic [GOS_AXES-1:0][7:0] GOS_OUT_HI_ADDR = {
      GOS_GYRO_Z_OUT_HIGH, GOS_GYRO_Y_OUT_HIGH, GOS_GYRO_X_OUT_HIGH};
   localparam logic [GOS_AXES-1:0][7:0] GOS_OUT_LO_ADDR = {
      GOS_GYRO_Z_OUT_LOW, GOS_GYRO_Y_OUT_LOW, GOS_GYRO_X_OUT_LOW};

   // ****************************************************************
   // values after reset
   // ****************************************************************
   // factory code default is arbitrary; real parts load trimmed values
   localparam logic [7:0] GOS_STORED_TEST_CODE_DEFAULT = 8'h80;
   localparam logic [15:0] GOS_BIAS_RST = 16'h0000;
   localparam logic [15:0] GOS_OUT_RST = 16'h0000;
   localparam logic [7:0] GOS_RDATA_RST = 8'h00;
   localparam logic [7:0] GOS_UNMAPPED_RDATA = 8'h00;
   localparam logic GOS_SLEEP_RST = 1'b1;

   // ****************************************************************
   // block state
   // ****************************************************************
   typedef struct packed {
      logic [GOS_ST_REGS-1:0][7:0] stored_test_code;
      logic [GOS_AXES-1:0][15:0] bias;
      logic [GOS_AXES-1:0][15:0] gyro_out;
      logic sleep;
      logic out_valid;
      logic [7:0] rdata;
      logic rvalid;
   } gos_state_t;

endpackage : gos_pkg

/* File: core/gos_bias_sat_add.sv */
`timescale 1ns/1ps
module gos_bias_sat_add #(
   parameter int W = 16
) (
   input wire logic [W-1:0] raw,
   input wire logic [W-1:0] bias,
   output logic [W-1:0] sum
);

   logic [W:0] wide;

   // ****************************************************************
   // signed add with clamp
   // ****************************************************************
   always_comb begin
      wide = {raw[W-1], raw} + {bias[W-1], bias};  // [R12]
      if (wide[W] != wide[W-1]) begin
         // clamp instead of wrap so a large bias never flips the sign
         sum = wide[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};  // [R15]
      end else begin
         sum = wide[W-1:0];
      end
   end

endmodule : gos_bias_sat_add

/* File: core/gos_regs.sv */
`timescale 1ns/1ps
// Contract
// R1 - device starts in sleep after power-up
// R2 - gyro self-test codes at 0x00-0x02
// R3 - accel self-test codes at 0x0D-0x0F
// R4 - host derives expected response from code
// R5 - code is rounded log-1.01 of response
// R6 - host compares later self-test with factory codes
// R7 - 0x13 holds X bias bits 15:8
// R8 - 0x14 holds X bias bits 7:0
// R9 - 0x15 holds Y bias bits 15:8
// R10 - 0x16 holds Y bias bits 7:0
// R11 - 0x17 holds Z bias bits 15:8
// R12 - bias added to raw sample before storing
// R13 - 0x18 holds Z bias bits 7:0
// R14 - codes reset to factory values, others zero
// R15 - sum saturates at signed 16-bit limits
module gos_regs #(
   parameter logic [7:0] GYRO_X_FACTORY_CODE = gos_pkg::GOS_STORED_TEST_CODE_DEFAULT,
   parameter logic [7:0] GYRO_Y_FACTORY_CODE = gos_pkg::GOS_STORED_TEST_CODE_DEFAULT,
   parameter logic [7:0] GYRO_Z_FACTORY_CODE = gos_pkg::GOS_STORED_TEST_CODE_DEFAULT,
   parameter logic [7:0] ACCEL_X_FACTORY_CODE = gos_pkg::GOS_STORED_TEST_CODE_DEFAULT,
   parameter logic [7:0] ACCEL_Y_FACTORY_CODE = gos_pkg::GOS_STORED_TEST_CODE_DEFAULT,
   parameter logic [7:0] ACCEL_Z_FACTORY_CODE = gos_pkg::GOS_STORED_TEST_CODE_DEFAULT
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic sleep_req,
   input wire logic wake_req,
   output logic sleep_state,
   input wire logic raw_valid,
   input wire logic [15:0] raw_gyro_x,
   input wire logic [15:0] raw_gyro_y,
   input wire logic [15:0] raw_gyro_z,
   output logic [15:0] gyro_x_out,
   output logic [15:0] gyro_y_out,
   output logic [15:0] gyro_z_out,
   output logic gyro_out_valid
);

   localparam int AX = gos_pkg::GOS_AXES;
   localparam int NST = gos_pkg::GOS_ST_REGS;

   // ****************************************************************
   // reset image
   // ****************************************************************
   localparam logic [NST-1:0][7:0] ST_RST = {
      ACCEL_Z_FACTORY_CODE, ACCEL_Y_FACTORY_CODE, ACCEL_X_FACTORY_CODE,
      GYRO_Z_FACTORY_CODE, GYRO_Y_FACTORY_CODE, GYRO_X_FACTORY_CODE};
   localparam gos_pkg::gos_state_t STATE_RST = '{
      stored_test_code: ST_RST,
      bias: {AX{gos_pkg::GOS_BIAS_RST}},
      gyro_out: {AX{gos_pkg::GOS_OUT_RST}},
      sleep: gos_pkg::GOS_SLEEP_RST,
      out_valid: 1'b0,
      rdata: gos_pkg::GOS_RDATA_RST,
      rvalid: 1'b0};

   gos_pkg::gos_state_t state_ff;
   gos_pkg::gos_state_t nxt_state;
   logic [AX-1:0][15:0] raw_arr;
   logic [AX-1:0][15:0] sum_arr;

   assign raw_arr = {raw_gyro_z, raw_gyro_y, raw_gyro_x};

   // ****************************************************************
   // read decode
   // ****************************************************************
   function automatic logic [7:0] gos_read_mux(
      input gos_pkg::gos_state_t s,
      input logic [7:0] addr
   );
      logic [7:0] d;
      d = gos_pkg::GOS_UNMAPPED_RDATA;
      for (int i = 0; i < NST; i++) begin
         if (addr == gos_pkg::GOS_ST_ADDR[i]) begin
            d = s.stored_test_code[i];
         end
      end
      for (int i = 0; i < AX; i++) begin
         if (addr == gos_pkg::GOS_BIAS_HI_ADDR[i]) begin
            d = s.bias[i][15:8];
         end else if (addr == gos_pkg::GOS_BIAS_LO_ADDR[i]) begin
            d = s.bias[i][7:0];
         end else if (addr == gos_pkg::GOS_OUT_HI_ADDR[i]) begin
            d = s.gyro_out[i][15:8];
         end else if (addr == gos_pkg::GOS_OUT_LO_ADDR[i]) begin
            d = s.gyro_out[i][7:0];
         end
      end
      return d;
   endfunction : gos_read_mux

   // ****************************************************************
   // per-axis bias adders
   // ****************************************************************
   generate
      for (genvar g = 0; g < AX; g++) begin : g_axis
         gos_bias_sat_add #(
            .W(16)
         ) u_add (
            .raw(raw_arr[g]),
            .bias(state_ff.bias[g]),
            .sum(sum_arr[g])
         );
      end
   endgenerate

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      nxt_state = state_ff;
      nxt_state.rvalid = 1'b0;
      nxt_state.out_valid = 1'b0;
      // sleep request wins if both arrive together
      if (wake_req) begin
         nxt_state.sleep = 1'b0;
      end
      if (sleep_req) begin
         nxt_state.sleep = 1'b1;  // [R1]
      end
      if (reg_wr) begin
         for (int i = 0; i < NST; i++) begin
            if (reg_addr == gos_pkg::GOS_ST_ADDR[i]) begin
               nxt_state.stored_test_code[i] = reg_wdata;  // [R2] [R3]
            end
         end
         for (int i = 0; i < AX; i++) begin
            if (reg_addr == gos_pkg::GOS_BIAS_HI_ADDR[i]) begin
               nxt_state.bias[i][15:8] = reg_wdata;  // [R7] [R9] [R11]
            end else if (reg_addr == gos_pkg::GOS_BIAS_LO_ADDR[i]) begin
               nxt_state.bias[i][7:0] = reg_wdata;  // [R8] [R10] [R13]
            end
         end
      end
      if (reg_rd) begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rdata = gos_read_mux(state_ff, reg_addr);
      end
      // no sample updates while asleep; output registers hold
      if (raw_valid && !state_ff.sleep) begin
         nxt_state.gyro_out = sum_arr;  // [R12]
         nxt_state.out_valid = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_ff <= STATE_RST;  // [R1] [R14]
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign reg_rdata = state_ff.rdata;
   assign reg_rvalid = state_ff.rvalid;
   assign sleep_state = state_ff.sleep;
   assign gyro_x_out = state_ff.gyro_out[0];
   assign gyro_y_out = state_ff.gyro_out[1];
   assign gyro_z_out = state_ff.gyro_out[2];
   assign gyro_out_valid = state_ff.out_valid;

endmodule : gos_regs

/* File: tb/gos_regs_sva.sv */
`timescale 1ns/1ps
module gos_regs_sva (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_rvalid,
   input wire logic sleep_req,
   input wire logic wake_req,
   input wire logic sleep_state,
   input wire logic raw_valid,
   input wire logic gyro_out_valid,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [15:0] raw_gyro_x,
   input wire logic [15:0] gyro_x_out,
   input wire logic [15:0] gyro_y_out
);
   // ****************************************************************
   // reference copy of the x bias
   // ****************************************************************
   logic [15:0] bias_x_ff, nxt_bias_x, exp_x;
   logic [7:0] exp_rd;
   logic signed [16:0] sum_x;
   always_comb begin
      nxt_bias_x = bias_x_ff;
      if (reg_wr && reg_addr == 8'h13) nxt_bias_x[15:8] = reg_wdata;
      if (reg_wr && reg_addr == 8'h14) nxt_bias_x[7:0] = reg_wdata;
      if (srst) nxt_bias_x = 16'h0000;
      exp_rd = (reg_addr == 8'h13) ? bias_x_ff[15:8] : bias_x_ff[7:0];
      sum_x = $signed({raw_gyro_x[15], raw_gyro_x}) + $signed({bias_x_ff[15], bias_x_ff});
      exp_x = (sum_x[16:15] == 2'b01) ? 16'h7FFF : (sum_x[16:15] == 2'b10) ? 16'h8000 : sum_x[15:0];
   end
   always_ff @(posedge clk_sys) bias_x_ff <= nxt_bias_x;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   rst_sleep_a: assert property (disable iff (1'b0) srst |=> sleep_state && !reg_rvalid)
      else $error("not asleep after reset");
   rst_zero_a: assert property (disable iff (1'b0) srst |=> reg_rdata == 8'h00 && gyro_x_out == 16'h0000)
      else $error("outputs not cleared by reset");
   rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
   rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray read answer");
   unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   bias_rd_a: assert property (reg_rd && (reg_addr == 8'h13 || reg_addr == 8'h14) |=> reg_rdata == $past(exp_rd))
      else $error("x bias read wrong");
   sample_x_a: assert property (raw_valid && !sleep_state |=> gyro_out_valid && gyro_x_out == $past(exp_x))
      else $error("x output not raw plus bias");
   drop_sample_a: assert property (!(raw_valid && !sleep_state) |=> !gyro_out_valid)
      else $error("sample taken while asleep");
   hold_out_a: assert property (!gyro_out_valid |-> $stable(gyro_y_out))
      else $error("y output moved without sample");
   sleep_cmd_a: assert property (sleep_req |=> sleep_state) else $error("sleep request ignored");
   wake_cmd_a: assert property (wake_req && !sleep_req |=> !sleep_state) else $error("wake ignored");
endmodule : gos_regs_sva
bind gos_regs gos_regs_sva u_sva (.clk_sys(clk_sys), .srst(srst), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .sleep_req(sleep_req), .wake_req(wake_req),
   .sleep_state(sleep_state), .raw_valid(raw_valid), .gyro_out_valid(gyro_out_valid),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .raw_gyro_x(raw_gyro_x), .gyro_x_out(gyro_x_out), .gyro_y_out(gyro_y_out));

/* File: tb/gos_host.sv */
`timescale 1ns/1ps
module gos_host (
   input wire logic clk_sys,
   input wire logic reg_rvalid,
   input wire logic [7:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // idle cycle before each access keeps strobes from being set twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      @(posedge clk_sys);
      #1 reg_addr = a;
      reg_wdata = dat;
      reg_wr = 1'b1;
      @(posedge clk_sys);
      #1 reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~dat;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] dat, output logic ok);
      @(posedge clk_sys);
      #1 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk_sys);
      #1 reg_rd = 1'b0;
      reg_addr = ~a;
      ok = 1'b0;
      dat = 8'h00;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (reg_rvalid === 1'b1) begin
            ok = 1'b1;
            dat = reg_rdata;
         end else @(posedge clk_sys) #1;
      end
   endtask : rd
   // host-side conversion of a stored code to its expected response, in lsb
   function automatic real resp_of(input logic [7:0] code, input int fs);
      return (2620.0 / (2.0 ** fs)) * (1.01 ** ($itor(code) - 1.0));
   endfunction : resp_of
   // rounding by +0.5 only holds for codes above one (positive log)
   function automatic logic [7:0] code_of(input real resp, input int fs);
      int c;
      c = $rtoi($ln(resp / (2620.0 / (2.0 ** fs))) / $ln(1.01) + 0.5) + 1;
      return c[7:0];
   endfunction : code_of
endmodule : gos_host

/* File: tb/test_gos_regs.sv */
`timescale 1ns/1ps
module test_gos_regs;
   logic clk_sys, srst, reg_wr, reg_rd, reg_rvalid, sleep_req, wake_req, sleep_state, ok;
   logic raw_valid, gyro_out_valid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [15:0] raw_gyro_x, raw_gyro_y, raw_gyro_z, gyro_x_out, gyro_y_out, gyro_z_out;
   logic [15:0] e;
   logic [15:0] bv [3] = '{16'h1234, 16'hFF00, 16'h8001};
   logic [15:0] rv [3] = '{16'h0010, 16'h7FF0, 16'h8000};
   int miscompares = 0;
   int tests_run = 0;
   gos_regs u_dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .sleep_req(sleep_req), .wake_req(wake_req), .sleep_state(sleep_state),
      .raw_valid(raw_valid), .raw_gyro_x(raw_gyro_x), .raw_gyro_y(raw_gyro_y),
      .raw_gyro_z(raw_gyro_z), .gyro_x_out(gyro_x_out), .gyro_y_out(gyro_y_out),
      .gyro_z_out(gyro_z_out), .gyro_out_valid(gyro_out_valid));
   gos_host u_host (.clk_sys(clk_sys), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   // an unanswered read counts as a mismatch
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      u_host.rd(a, d, ok);
      chk({15'h0000, ok}, 16'h0001);
      if (ok !== 1'b1) end_sim();
      chk({8'h00, d}, {8'h00, exp});
   endtask : rdchk
   task automatic smp(input logic [15:0] r);
      @(posedge clk_sys);
      #1 {raw_gyro_x, raw_gyro_y, raw_gyro_z} = {r, r, r};
      raw_valid = 1'b1;
      @(posedge clk_sys);
      #1 raw_valid = 1'b0;
      {raw_gyro_x, raw_gyro_y, raw_gyro_z} = {~r, ~r, ~r};
   endtask : smp
   function automatic logic [15:0] sat(input logic [15:0] r, input logic [15:0] b);
      logic signed [16:0] s;
      s = $signed({r[15], r}) + $signed({b[15], b});
      if (s > 17'sh07FFF) return 16'h7FFF;
      if (s < -17'sh08000) return 16'h8000;
      return s[15:0];
   endfunction : sat
   task automatic pulse_ctl(input logic slp);
      @(posedge clk_sys);
      #1 {sleep_req, wake_req} = {slp, ~slp};
      @(posedge clk_sys);
      #1 {sleep_req, wake_req} = 2'b00;
      chk({15'h0000, sleep_state}, {15'h0000, slp});
   endtask : pulse_ctl
   initial begin
      {srst, sleep_req, wake_req, raw_valid} = 4'b1000;
      {raw_gyro_x, raw_gyro_y, raw_gyro_z} = '0;
      repeat (3) @(posedge clk_sys);
      #1 srst = 1'b0;
      chk({15'h0000, sleep_state}, 16'h0001);
      for (int i = 0; i < 6; i++) rdchk(gos_pkg::GOS_ST_ADDR[i], gos_pkg::GOS_STORED_TEST_CODE_DEFAULT);
      for (int fs = 0; fs < 4; fs++) begin
         e = {8'h00, u_host.code_of(u_host.resp_of(d, fs), fs)};
         chk(e, {8'h00, gos_pkg::GOS_STORED_TEST_CODE_DEFAULT});
      end
      for (int i = 0; i < 3; i++) begin
         rdchk(gos_pkg::GOS_BIAS_HI_ADDR[i], 8'h00);
         rdchk(gos_pkg::GOS_BIAS_LO_ADDR[i], 8'h00);
      end
      smp(16'h0001);
      chk({15'h0000, gyro_out_valid}, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         u_host.wr(gos_pkg::GOS_BIAS_HI_ADDR[i], bv[i][15:8]);
         u_host.wr(gos_pkg::GOS_BIAS_LO_ADDR[i], bv[i][7:0]);
         rdchk(gos_pkg::GOS_BIAS_HI_ADDR[i], bv[i][15:8]);
         rdchk(gos_pkg::GOS_BIAS_LO_ADDR[i], bv[i][7:0]);
      end
      u_host.wr(8'h0E, 8'h5A);
      rdchk(8'h0E, 8'h5A);
      rdchk(8'h20, 8'h00);
      pulse_ctl(1'b0);
      for (int k = 0; k < 3; k++) begin
         smp(rv[k]);
         chk({15'h0000, gyro_out_valid}, 16'h0001);
         chk(gyro_x_out, sat(rv[k], bv[0]));
         chk(gyro_y_out, sat(rv[k], bv[1]));
         chk(gyro_z_out, sat(rv[k], bv[2]));
      end
      e = sat(rv[2], bv[0]);
      rdchk(gos_pkg::GOS_OUT_HI_ADDR[0], e[15:8]);
      rdchk(gos_pkg::GOS_OUT_LO_ADDR[0], e[7:0]);
      u_host.wr(gos_pkg::GOS_OUT_HI_ADDR[0], 8'hA5);
      rdchk(gos_pkg::GOS_OUT_HI_ADDR[0], e[15:8]);
      pulse_ctl(1'b1);
      // second reset must restore factory codes and clear biases and outputs
      @(posedge clk_sys);
      #1 srst = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 srst = 1'b0;
      chk(gyro_x_out, gos_pkg::GOS_OUT_RST);
      chk({15'h0000, sleep_state}, 16'h0001);
      rdchk(8'h0E, gos_pkg::GOS_STORED_TEST_CODE_DEFAULT);
      rdchk(gos_pkg::GOS_BIAS_HI_ADDR[0], 8'h00);
      end_sim();
   end
endmodule : test_gos_regs
